// ===== verilog/bwcr_pkg.sv
// constants shared by the bridge window configuration register bank
package bwcr_pkg;
  // register bus geometry
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int STRB_W = DATA_W / 8;

  // word offsets of the implemented registers
  localparam logic [7:0] OFS_PF_WINDOW = 8'h24;
  localparam logic [7:0] OFS_PF_BOTTOM_HI = 8'h28;
  localparam logic [7:0] OFS_PF_TOP_HI = 8'h2C;
  localparam logic [7:0] OFS_IO_WINDOW_HI = 8'h30;
  localparam logic [7:0] OFS_CAP_HEAD = 8'h34;
  localparam logic [7:0] OFS_IRQ_BYTES = 8'h3C;

  // field positions
  localparam int PF_BASE_LSB = 4;
  localparam int PF_LIMIT_LSB = 20;
  localparam int PF_CODE_HI_LSB = 16;
  localparam int PF_FIELD_W = 12;
  localparam int PF_LOW_W = 20;
  localparam int IO_LIMIT_LSB = 16;
  localparam int IRQ_PIN_LSB = 8;

  // fixed read values
  localparam logic [3:0] ADDR64_CODE = 4'h1;
  localparam logic [7:0] CAP_HEAD_VAL = 8'h80;
  localparam logic [7:0] IRQ_PIN_VAL = 8'h00;

  // reset values
  localparam logic [11:0] PF_FIELD_RST = 12'h000;
  localparam logic [31:0] PF_HI_RST = 32'h0000_0000;
  localparam logic [15:0] IO_HI_RST = 16'h0000;
  localparam logic [7:0] IRQ_LINE_RST = 8'hFF;

  // bus answers
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : bwcr_pkg

// ===== verilog/bwcr_strb_merge.sv
// byte-lane merge of write data into the current register word
module bwcr_strb_merge
  import bwcr_pkg::*;
#(
  parameter int W = 32
)
(
  input wire logic [W-1:0] i_old,
  input wire logic [W-1:0] i_wdata,
  input wire logic [W/8-1:0] i_strb,
  output logic [W-1:0] o_merged
);

  // each strobe selects one byte lane of the new data
  always_comb
  begin
    o_merged = i_old;
    for (int b = 0; b < W / 8; b++)
    begin
      if (i_strb[b])
      begin
        o_merged[b*8 +: 8] = i_wdata[b*8 +: 8];
      end
    end
  end
endmodule : bwcr_strb_merge

// ===== verilog/bwcr_window_match.sv
// registered inclusive range check of an address against a window
module bwcr_window_match
  import bwcr_pkg::*;
#(
  parameter int AW = 64
)
(
  input wire logic i_ref_clk,
  input wire logic i_rst,
  input wire logic [AW-1:0] i_addr,
  input wire logic [AW-1:0] i_base,
  input wire logic [AW-1:0] i_limit,
  output logic o_hit
);

  typedef struct packed {
    logic hit;
  } bwcr_match_type;

  bwcr_match_type s_reg;
  bwcr_match_type s_next;

  // both ends of the window count as inside
  always_comb
  begin
    s_next = s_reg;
    s_next.hit = (i_addr >= i_base) && (i_addr <= i_limit);
  end

  always_ff @(posedge i_ref_clk)
  begin
    if (i_rst)
    begin
      s_reg <= '0;
    end
    else
    begin
      s_reg <= s_next;
    end
  end

  assign o_hit = s_reg.hit;
endmodule : bwcr_window_match

// ===== verilog/bwcr_top.sv
// window configuration register bank of the bridge, reached over axi4-lite
// Function
// - window halfwords read low nibble as 0001
// - base field bits 15:4, low bits zero
// - limit field bits 31:20, low bits ones
// - upper base word writable, resets zero
// - upper limit word writable, resets zero
// - 64-bit base is upper, field, zeros
// - 64-bit limit is upper, field, ones
// - io bottom upper bits 15:0, reset zero
// - io top upper bits 31:16, reset zero
// - capability pointer reads fixed 80h
// - interrupt line byte is plain storage
// - interrupt pin byte reads zero
//
// Decided for this implementation: register access over AXI4-Lite.
module bwcr_top
  import bwcr_pkg::*;
(
  input wire logic i_ref_clk,
  input wire logic i_rst,
  // axi4-lite write address
  input wire logic i_s_axi_awvalid,
  output logic o_s_axi_awready,
  input wire logic [ADDR_W-1:0] i_s_axi_awaddr,
  // axi4-lite write data
  input wire logic i_s_axi_wvalid,
  output logic o_s_axi_wready,
  input wire logic [DATA_W-1:0] i_s_axi_wdata,
  input wire logic [STRB_W-1:0] i_s_axi_wstrb,
  // axi4-lite write response
  output logic o_s_axi_bvalid,
  input wire logic i_s_axi_bready,
  output logic [1:0] o_s_axi_bresp,
  // axi4-lite read address
  input wire logic i_s_axi_arvalid,
  output logic o_s_axi_arready,
  input wire logic [ADDR_W-1:0] i_s_axi_araddr,
  // axi4-lite read data
  output logic o_s_axi_rvalid,
  input wire logic i_s_axi_rready,
  output logic [DATA_W-1:0] o_s_axi_rdata,
  output logic [1:0] o_s_axi_rresp,
  // window values for the forwarding decode, plus the stored interrupt line byte
  output logic [63:0] o_pf_base,
  output logic [63:0] o_pf_limit,
  output logic [15:0] o_io_base_hi,
  output logic [15:0] o_io_limit_hi,
  output logic [7:0] o_irq_line,
  // prefetchable window check
  input wire logic [63:0] i_mem_addr,
  output logic o_mem_in_window
);

  typedef struct packed {
    logic aw_held;
    logic [ADDR_W-1:0] aw_addr;
    logic w_held;
    logic [DATA_W-1:0] w_data;
    logic [STRB_W-1:0] w_strb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [DATA_W-1:0] rdata;
    logic [1:0] rresp;
    logic [PF_FIELD_W-1:0] pf_base;
    logic [PF_FIELD_W-1:0] pf_limit;
    logic [31:0] pf_base_hi;
    logic [31:0] pf_limit_hi;
    logic [15:0] io_base_hi;
    logic [15:0] io_limit_hi;
    logic [7:0] irq_line;
  } bwcr_state_type;

  bwcr_state_type s_reg;
  bwcr_state_type s_next;
  logic [DATA_W-1:0] wr_old;
  logic [DATA_W-1:0] wr_merged;
  logic wr_fire;

  // word select ignores the byte-in-word address bits
  function automatic logic [7:0] word_of(input logic [ADDR_W-1:0] a);
    word_of = {a[7:2], 2'b00};
  endfunction : word_of

  function automatic logic is_mapped(input logic [ADDR_W-1:0] a);
    case (word_of(a))
      OFS_PF_WINDOW, OFS_PF_BOTTOM_HI, OFS_PF_TOP_HI,
      OFS_IO_WINDOW_HI, OFS_CAP_HEAD, OFS_IRQ_BYTES: is_mapped = 1'b1;
      default: is_mapped = 1'b0;
    endcase
  endfunction : is_mapped

  // readback view of the register words, fixed fields included
  function automatic logic [DATA_W-1:0] read_word(input logic [ADDR_W-1:0] a,
                                                  input bwcr_state_type s);
    read_word = '0;
    case (word_of(a))
      OFS_PF_WINDOW:
      begin
        read_word[3:0] = ADDR64_CODE;
        read_word[PF_CODE_HI_LSB +: 4] = ADDR64_CODE;
        read_word[PF_BASE_LSB +: PF_FIELD_W] = s.pf_base;
        read_word[PF_LIMIT_LSB +: PF_FIELD_W] = s.pf_limit;
      end
      OFS_PF_BOTTOM_HI: read_word = s.pf_base_hi;
      OFS_PF_TOP_HI: read_word = s.pf_limit_hi;
      OFS_IO_WINDOW_HI:
      begin
        read_word[15:0] = s.io_base_hi;
        read_word[IO_LIMIT_LSB +: 16] = s.io_limit_hi;
      end
      OFS_CAP_HEAD: read_word[7:0] = CAP_HEAD_VAL;
      OFS_IRQ_BYTES:
      begin
        read_word[7:0] = s.irq_line;
        read_word[IRQ_PIN_LSB +: 8] = IRQ_PIN_VAL;
      end
      default: read_word = '0;
    endcase
  endfunction : read_word

  // address and data may arrive in either order; each is held until both are in
  assign o_s_axi_awready = !s_reg.aw_held && !s_reg.bvalid;
  assign o_s_axi_wready = !s_reg.w_held && !s_reg.bvalid;
  assign o_s_axi_arready = !s_reg.rvalid;
  assign wr_fire = s_reg.aw_held && s_reg.w_held && !s_reg.bvalid;
  assign wr_old = read_word(s_reg.aw_addr, s_reg);

  // partial writes keep the untouched byte lanes
  bwcr_strb_merge #(
    .W(DATA_W)
  ) u_merge (
    .i_old(wr_old),
    .i_wdata(s_reg.w_data),
    .i_strb(s_reg.w_strb),
    .o_merged(wr_merged)
  );

  // bus handshakes and register updates
  always_comb
  begin
    s_next = s_reg;
    if (i_s_axi_awvalid && o_s_axi_awready)
    begin
      s_next.aw_held = 1'b1;
      s_next.aw_addr = i_s_axi_awaddr;
    end
    if (i_s_axi_wvalid && o_s_axi_wready)
    begin
      s_next.w_held = 1'b1;
      s_next.w_data = i_s_axi_wdata;
      s_next.w_strb = i_s_axi_wstrb;
    end
    if (s_reg.bvalid && i_s_axi_bready)
    begin
      s_next.bvalid = 1'b0;
    end
    if (wr_fire)
    begin
      s_next.aw_held = 1'b0;
      s_next.w_held = 1'b0;
      s_next.bvalid = 1'b1;
      s_next.bresp = is_mapped(s_reg.aw_addr) ? RESP_OKAY : RESP_SLVERR;
      // read-only fields are simply not stored; the write still answers okay
      case (word_of(s_reg.aw_addr))
        OFS_PF_WINDOW:
        begin
          s_next.pf_base = wr_merged[PF_BASE_LSB +: PF_FIELD_W];
          s_next.pf_limit = wr_merged[PF_LIMIT_LSB +: PF_FIELD_W];
        end
        OFS_PF_BOTTOM_HI: s_next.pf_base_hi = wr_merged;
        OFS_PF_TOP_HI: s_next.pf_limit_hi = wr_merged;
        OFS_IO_WINDOW_HI:
        begin
          s_next.io_base_hi = wr_merged[15:0];
          s_next.io_limit_hi = wr_merged[IO_LIMIT_LSB +: 16];
        end
        OFS_IRQ_BYTES: s_next.irq_line = wr_merged[7:0];
        default:
        begin
          s_next.bresp = s_next.bresp;
        end
      endcase
    end
    if (s_reg.rvalid && i_s_axi_rready)
    begin
      s_next.rvalid = 1'b0;
    end
    if (i_s_axi_arvalid && o_s_axi_arready)
    begin
      s_next.rvalid = 1'b1;
      s_next.rdata = read_word(i_s_axi_araddr, s_reg);
      s_next.rresp = is_mapped(i_s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
    end
  end

  // state register; window fields reset to zero, which leaves the prefetch window open from 0 to FFFFFh
  always_ff @(posedge i_ref_clk)
  begin
    if (i_rst)
    begin
      s_reg <= '0;
      s_reg.pf_base <= PF_FIELD_RST;
      s_reg.pf_limit <= PF_FIELD_RST;
      s_reg.pf_base_hi <= PF_HI_RST;
      s_reg.pf_limit_hi <= PF_HI_RST;
      s_reg.io_base_hi <= IO_HI_RST;
      s_reg.io_limit_hi <= IO_HI_RST;
      s_reg.irq_line <= IRQ_LINE_RST;
    end
    else
    begin
      s_reg <= s_next;
    end
  end

  // bus outputs come straight from the state flops
  assign o_s_axi_bvalid = s_reg.bvalid;
  assign o_s_axi_bresp = s_reg.bresp;
  assign o_s_axi_rvalid = s_reg.rvalid;
  assign o_s_axi_rdata = s_reg.rdata;
  assign o_s_axi_rresp = s_reg.rresp;

  // assembled 64-bit window ends for the forwarding decode
  assign o_pf_base = {s_reg.pf_base_hi, s_reg.pf_base, {PF_LOW_W{1'b0}}};
  assign o_pf_limit = {s_reg.pf_limit_hi, s_reg.pf_limit, {PF_LOW_W{1'b1}}};
  assign o_io_base_hi = s_reg.io_base_hi;
  assign o_io_limit_hi = s_reg.io_limit_hi;
  assign o_irq_line = s_reg.irq_line;

  // one-cycle registered check keeps the 64-bit compares off the decode path
  bwcr_window_match #(
    .AW(64)
  ) u_pf_match (
    .i_ref_clk(i_ref_clk),
    .i_rst(i_rst),
    .i_addr(i_mem_addr),
    .i_base(o_pf_base),
    .i_limit(o_pf_limit),
    .o_hit(o_mem_in_window)
  );

  // checks on the register file behaviour
  default clocking cb @(posedge i_ref_clk);
  endclocking
  default disable iff (i_rst);

  logic ar_take;
  logic full_wr;
  assign ar_take = i_s_axi_arvalid && o_s_axi_arready;
  assign full_wr = wr_fire && (s_reg.w_strb == 4'hF);

  a_pf_code_read: assert property (
    ar_take && (word_of(i_s_axi_araddr) == OFS_PF_WINDOW)
    |=> o_s_axi_rdata[3:0] == ADDR64_CODE && o_s_axi_rdata[19:16] == ADDR64_CODE)
    else $error("window word lost its 64-bit code");

  a_pf_base_write: assert property (
    full_wr && (word_of(s_reg.aw_addr) == OFS_PF_WINDOW)
    |=> o_pf_base[31:20] == $past(s_reg.w_data[15:4]) && o_pf_base[19:0] == 20'h00000)
    else $error("base field not taken from bits 15:4");

  a_pf_limit_write: assert property (
    full_wr && (word_of(s_reg.aw_addr) == OFS_PF_WINDOW)
    |=> o_pf_limit[31:20] == $past(s_reg.w_data[31:20]) && o_pf_limit[19:0] == 20'hFFFFF)
    else $error("limit field not taken from bits 31:20");

  a_base_hi_write: assert property (
    full_wr && (word_of(s_reg.aw_addr) == OFS_PF_BOTTOM_HI)
    |=> o_pf_base[63:32] == $past(s_reg.w_data))
    else $error("upper base word not stored");

  a_limit_hi_write: assert property (
    full_wr && (word_of(s_reg.aw_addr) == OFS_PF_TOP_HI)
    |=> o_pf_limit[63:32] == $past(s_reg.w_data))
    else $error("upper limit word not stored");

  a_io_hi_write: assert property (
    full_wr && (word_of(s_reg.aw_addr) == OFS_IO_WINDOW_HI)
    |=> o_io_base_hi == $past(s_reg.w_data[15:0]) && o_io_limit_hi == $past(s_reg.w_data[31:16]))
    else $error("io upper halves not stored");

  a_reset_clear: assert property (
    $past(i_rst) |-> o_pf_base[63:32] == 32'h0000_0000 && o_pf_limit[63:32] == 32'h0000_0000
      && o_io_base_hi == 16'h0000 && o_io_limit_hi == 16'h0000)
    else $error("window registers not cleared by reset");

  a_cap_head_read: assert property (
    ar_take && (word_of(i_s_axi_araddr) == OFS_CAP_HEAD)
    |=> o_s_axi_rvalid && o_s_axi_rdata == 32'h0000_0080 && o_s_axi_rresp == RESP_OKAY)
    else $error("capability pointer not 80h");

  a_irq_line_store: assert property (
    wr_fire && s_reg.w_strb[0] && (word_of(s_reg.aw_addr) == OFS_IRQ_BYTES)
    |=> o_irq_line == $past(s_reg.w_data[7:0]))
    else $error("interrupt line byte not stored");

  a_irq_pin_zero: assert property (
    ar_take && (word_of(i_s_axi_araddr) == OFS_IRQ_BYTES)
    |=> o_s_axi_rdata[15:8] == 8'h00 && o_s_axi_rdata[31:16] == 16'h0000)
    else $error("interrupt pin byte not zero");

  a_window_hit: assert property (
    !i_rst |=> o_mem_in_window == ($past(i_mem_addr) >= $past(o_pf_base)
      && $past(i_mem_addr) <= $past(o_pf_limit)))
    else $error("window hit disagrees with base and limit");

  a_bresp_hold: assert property (
    o_s_axi_bvalid && !i_s_axi_bready |=> o_s_axi_bvalid && $stable(o_s_axi_bresp))
    else $error("write response dropped before accepted");

  a_write_answer: assert property (
    wr_fire |=> o_s_axi_bvalid ##0 !o_s_axi_awready [*1])
    else $error("write not answered one cycle after both parts held");

  // read answers one cycle after the address and then holds until taken
  a_read_answer: assert property (
    ar_take |=> o_s_axi_rvalid && !o_s_axi_arready)
    else $error("read not answered one cycle after address taken");

  a_rdata_hold: assert property (
    o_s_axi_rvalid && !i_s_axi_rready
    |=> o_s_axi_rvalid && $stable(o_s_axi_rdata) && $stable(o_s_axi_rresp))
    else $error("read data changed before accepted");

  a_unmapped_read: assert property (
    ar_take && !is_mapped(i_s_axi_araddr)
    |=> o_s_axi_rresp == RESP_SLVERR && o_s_axi_rdata == 32'h0000_0000)
    else $error("hole in the map did not answer with an error");

  a_unmapped_write: assert property (
    wr_fire && !is_mapped(s_reg.aw_addr)
    |=> o_s_axi_bresp == RESP_SLVERR && $stable(o_pf_base) && $stable(o_pf_limit) && $stable(o_irq_line))
    else $error("write to a hole changed state or answered okay");

  // a write that leaves the low lanes unselected must not touch the io bottom half
  a_partial_keep: assert property (
    wr_fire && s_reg.w_strb[1:0] == 2'b00 && (word_of(s_reg.aw_addr) == OFS_IO_WINDOW_HI)
    |=> $stable(o_io_base_hi))
    else $error("unselected byte lanes of the io word changed");

  // main scenarios
  c_window_write: cover property (full_wr && word_of(s_reg.aw_addr) == OFS_PF_WINDOW);
  c_cap_read: cover property (ar_take && word_of(i_s_axi_araddr) == OFS_CAP_HEAD);
  c_in_window: cover property (o_mem_in_window && o_pf_base[63:32] != 32'h0000_0000);
  c_unmapped_read: cover property (o_s_axi_rvalid && o_s_axi_rresp == RESP_SLVERR);
  c_partial_write: cover property (wr_fire && s_reg.w_strb != 4'hF);
endmodule : bwcr_top

// ===== bench/tb_bridge_window_config_regs.sv
// self-checking bench for the bridge window configuration register bank
module tb_bridge_window_config_regs
  import bwcr_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;

  logic clk = 1'b0;
  logic rst = 1'b1;
  logic awvalid, wvalid, bready, arvalid, rready, awready, wready, bvalid, arready, rvalid, hit;
  logic [7:0] awaddr, araddr, irq_line;
  logic [31:0] wdata, rdata, rd_val;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, rsp;
  logic [63:0] mem_addr, pf_base, pf_limit;
  logic [15:0] io_base, io_limit;
  int error_cnt = 0;
  int checks_done = 0;

  // free-running 100 MHz clock
  always #5 clk = ~clk;

  bwcr_top dut (
    .i_ref_clk(clk), .i_rst(rst),
    .i_s_axi_awvalid(awvalid), .o_s_axi_awready(awready), .i_s_axi_awaddr(awaddr),
    .i_s_axi_wvalid(wvalid), .o_s_axi_wready(wready), .i_s_axi_wdata(wdata), .i_s_axi_wstrb(wstrb),
    .o_s_axi_bvalid(bvalid), .i_s_axi_bready(bready), .o_s_axi_bresp(bresp),
    .i_s_axi_arvalid(arvalid), .o_s_axi_arready(arready), .i_s_axi_araddr(araddr),
    .o_s_axi_rvalid(rvalid), .i_s_axi_rready(rready), .o_s_axi_rdata(rdata), .o_s_axi_rresp(rresp),
    .o_pf_base(pf_base), .o_pf_limit(pf_limit), .o_io_base_hi(io_base), .o_io_limit_hi(io_limit),
    .o_irq_line(irq_line), .i_mem_addr(mem_addr), .o_mem_in_window(hit)
  );

  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  // bus write; address and data offered together, each released when taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s, output logic [1:0] r);
    logic aw_ok;
    logic w_ok;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    awaddr <= a;
    wdata <= d;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    while (!(aw_ok && w_ok))
    begin
      @(posedge clk);
      if (awvalid && awready)
      begin
        aw_ok = 1'b1;
        awvalid <= 1'b0;
      end
      if (wvalid && wready)
      begin
        w_ok = 1'b1;
        wvalid <= 1'b0;
      end
    end
    bready <= 1'b1;
    do @(posedge clk); while (!bvalid);
    r = bresp;
    bready <= 1'b0;
  endtask : wr

  // bus read; rready held until the answer is sampled
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    araddr <= a;
    arvalid <= 1'b1;
    do @(posedge clk); while (!arready);
    arvalid <= 1'b0;
    rready <= 1'b1;
    do @(posedge clk); while (!rvalid);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask : rd

  // every register word straight after reset
  task automatic t_reset();
    logic [7:0] ofs [6] = '{8'h24, 8'h28, 8'h2C, 8'h30, 8'h34, 8'h3C};
    logic [31:0] exp [6] = '{32'h0001_0001, 32'h0, 32'h0, 32'h0, 32'h0000_0080, 32'h0000_00FF};
    for (int i = 0; i < 6; i++)
    begin
      rd(ofs[i], rd_val, rsp);
      chk({rsp, rd_val}, {RESP_OKAY, exp[i]});
    end
    chk(pf_limit, 64'h0000_0000_000F_FFFF);
  endtask : t_reset

  // prefetch window fields, read-only code nibbles and assembled 64-bit values
  task automatic t_pf();
    wr(8'h24, 32'hFFFF_FFFF, 4'hF, rsp);
    rd(8'h24, rd_val, rsp);
    chk(rd_val, 32'hFFF1_FFF1);
    wr(8'h24, 32'h4560_1230, 4'hF, rsp);
    wr(8'h28, 32'h0000_0001, 4'hF, rsp);
    wr(8'h2C, 32'h0000_0001, 4'hF, rsp);
    rd(8'h24, rd_val, rsp);
    chk(rd_val, 32'h4561_1231);
    rd(8'h2C, rd_val, rsp);
    chk(rd_val, 32'h0000_0001);
    chk(pf_base, 64'h0000_0001_1230_0000);
    chk(pf_limit, 64'h0000_0001_456F_FFFF);
  endtask : t_pf

  // io upper halves with a one-lane write, interrupt bytes, fixed pointer
  task automatic t_io_irq();
    wr(8'h30, 32'h1111_2222, 4'hF, rsp);
    wr(8'h30, 32'hAAAA_BBBB, 4'h8, rsp);
    rd(8'h30, rd_val, rsp);
    chk(rd_val, 32'hAA11_2222);
    chk({io_limit, io_base}, 32'hAA11_2222);
    wr(8'h3C, 32'hFFFF_FF5A, 4'hF, rsp);
    rd(8'h3C, rd_val, rsp);
    chk(rd_val, 32'h0000_005A);
    wr(8'h3C, 32'h0000_00FF, 4'h1, rsp);
    chk(irq_line, 8'hFF);
    wr(8'h34, 32'h0000_0012, 4'hF, rsp);
    chk(rsp, RESP_OKAY);
    rd(8'h34, rd_val, rsp);
    chk(rd_val, 32'h0000_0080);
  endtask : t_io_irq

  // holes in the map answer with an error and leave state alone
  task automatic t_unmapped();
    wr(8'h38, 32'h1234_5678, 4'hF, rsp);
    chk(rsp, RESP_SLVERR);
    rd(8'h38, rd_val, rsp);
    chk({rsp, rd_val}, {RESP_SLVERR, 32'h0});
    chk(pf_base, 64'h0000_0001_1230_0000);
  endtask : t_unmapped

  task automatic win(input logic [63:0] a, input logic exp);
    @(posedge clk);
    mem_addr <= a;
    @(posedge clk);
    #1;
    chk(hit, exp);
  endtask : win

  // both inclusive edges of the window and one step outside each
  task automatic t_window();
    win(64'h0000_0001_122F_FFFF, 1'b0);
    win(64'h0000_0001_1230_0000, 1'b1);
    win(64'h0000_0001_456F_FFFF, 1'b1);
    win(64'h0000_0001_4570_0000, 1'b0);
    win(64'h0000_0000_1230_0000, 1'b0);
  endtask : t_window

  // second reset in mid-run clears the upper halves again
  task automatic t_rerst();
    @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rd(8'h28, rd_val, rsp);
    chk(rd_val, 32'h0);
    chk(pf_limit, 64'h0000_0000_000F_FFFF);
  endtask : t_rerst

  task automatic tally_and_finish();
    if (error_cnt == 0 && checks_done > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : tally_and_finish

  // main sequence
  initial
  begin
    {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
    {awaddr, araddr, wstrb} = 20'h00000;
    wdata = 32'h0;
    mem_addr = 64'h0;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    t_reset();
    t_pf();
    t_io_irq();
    t_unmapped();
    t_window();
    t_rerst();
    tally_and_finish();
  end

  // watchdog, far beyond the fewer than a hundred cycles the tests need
  initial
  begin
    repeat (20000) @(posedge clk);
    error_cnt++;
    tally_and_finish();
  end
endmodule : tb_bridge_window_config_regs
